// *** include/sweb_pkg.sv ***
// sweb_pkg: constants and types of the single-wire bus slave
// assumes a 10 MHz system clock on the slave side
package sweb_pkg;
  // system clock rate
  localparam int CLK_HZ = 10_000_000;
  // standby pulse, least high time on the line
  localparam int STBY_US = 600;
  localparam int STBY_CYC = (STBY_US * (CLK_HZ / 1_000_000));
  // start header low pulse, least low time
  localparam int HDR_US = 5;
  localparam int HDR_CYC = (HDR_US * (CLK_HZ / 1_000_000));
  // identity: arbitrary neutral family code, device code per variant
  localparam logic [3:0] FAMILY_CODE = 4'h5;
  localparam logic [3:0] DEVICE_CODE = 4'h0;
  // command codes
  localparam logic [7:0] CMD_RD = 8'h03;
  localparam logic [7:0] CMD_CUR_RD = 8'h06;
  localparam logic [7:0] CMD_WR = 8'h6c;
  localparam logic [7:0] CMD_LATCH_SET = 8'h96;
  localparam logic [7:0] CMD_LATCH_CLR = 8'h91;
  localparam logic [7:0] CMD_STAT_RD = 8'h05;
  localparam logic [7:0] CMD_STAT_WR = 8'h6e;
  localparam logic [7:0] CMD_FILL_ZERO = 8'h6d;
  localparam logic [7:0] CMD_FILL_ONE = 8'h67;
  // bit slots of one byte frame
  localparam logic [3:0] SLOT_MAK = 4'h8;
  localparam logic [3:0] SLOT_SAK = 4'h9;
  // header: first slot after the period is measured
  localparam logic [3:0] SLOT_HDR_RESUME = 4'h5;
  // buffer depth
  localparam int BUF_DEPTH = 2;
  // line state
  typedef enum {ST_IDLE, ST_STBY, ST_HLOW, ST_SYNC, ST_BITS} sweb_state_t;
  // byte phase inside a command
  typedef enum {PH_HDR, PH_ADDR, PH_CMD, PH_AHI, PH_ALO, PH_DRX, PH_DTX} sweb_phase_t;
  // received word toward user logic
  typedef struct packed {
    logic       is_data;
    logic [7:0] data;
  } sweb_word_t;
endpackage

// *** rtl/sweb_slave.sv ***
// sweb_slave: protocol engine of a single-wire manchester memory slave
// assumes an external pull-up on the line and same-clock user logic
//
// Overview of operation
// - bytes travel msb first, lsb last
// - manchester bits, master sets bit period
// - eight-bit command register after address
// - long high line resets into standby
// - falling edge leaves standby, starts header
// - header low then 01010101 sets period
// - two-bit acknowledge after every byte
// - master ack one continues, zero ends
// - no write cycle without data byte, fill commands aside
// - slave ack one; missing means no edge
// - withhold ack in five listed cases
// - address byte is family plus device
// - standby after clean end or pulse
// - idle on bad address, command, edge
// - idle on continue after no-data commands
// - short header low idles; other bad header shows as missed edge
// - re-align bit timing on master ack
`timescale 1ns/1ps
`default_nettype none
module sweb_slave #(
  parameter logic [3:0]  FAMILY  = sweb_pkg::FAMILY_CODE,
  parameter logic [3:0]  DEVCODE = sweb_pkg::DEVICE_CODE,
  parameter logic [15:0] STBY_CYC = 16'(sweb_pkg::STBY_CYC),
  parameter logic [15:0] HDR_CYC = 16'(sweb_pkg::HDR_CYC),
  parameter int          CW = 14
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              serial_line_in,
  output logic                   serial_line_out,
  output logic                   serial_line_oe,
  input  wire logic              write_busy,
  output logic                   write_start,
  output logic [7:0]             cmd_code,
  output logic                   standby,
  output logic                   idle,
  output sweb_pkg::sweb_word_t   rx_word,
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready
);
  // line synchroniser and edge history
  logic ln_s1_r, ln_s2_r, ln_d_r;
  // control state
  sweb_pkg::sweb_state_t st_r, st_nxt, go_r, go_nxt;
  sweb_pkg::sweb_phase_t ph_r, ph_nxt, nph_r, nph_nxt;
  logic [3:0]    slot_r, slot_nxt;    // bit slot in byte frame
  logic [CW-1:0] cnt_r, cnt_nxt;      // cycles since last mid edge
  logic [CW-1:0] per_r, per_nxt;      // measured bit period
  logic [1:0]    nfall_r, nfall_nxt;  // header falls seen
  logic [15:0]   hi_r, hi_nxt;        // cycles high since last edge
  logic [7:0]    sh_r, sh_nxt;        // receive shifter
  logic [7:0]    txs_r, txs_nxt;      // transmit shifter
  logic [7:0]    cmd_r, cmd_nxt;      // command register
  logic          sak_r, sak_nxt;      // acknowledge to send
  logic          drv_r, drv_nxt;      // driven level
  logic          oe_r, oe_nxt;        // drive enable
  logic          ws_r, ws_nxt;        // write cycle start pulse
  // combinational helpers
  logic edge_w, fall_w, rise_w, stby_w, is_tx_w, end_w, bitv_w, push_w, pop_w, full_w, tx_bit_w, cmd_ok_w;
  logic [CW-1:0] half_w, qtr_w;
  logic          leave_w;             // closing ack slot held one cycle
  // two-entry buffer
  sweb_pkg::sweb_word_t buf_r [sweb_pkg::BUF_DEPTH];
  sweb_pkg::sweb_word_t pword_w;
  logic       wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] bcnt_r, bcnt_nxt;

  // two flops before any logic reads the pin
  always_ff @(posedge mclk) begin
    if (reset) begin
      ln_s1_r <= 1'b1;
      ln_s2_r <= 1'b1;
      ln_d_r  <= 1'b1;
    end else begin
      ln_s1_r <= serial_line_in;
      ln_s2_r <= ln_s1_r;
      ln_d_r  <= ln_s2_r;
    end
  end

  assign edge_w = ln_s2_r ^ ln_d_r;
  assign fall_w = edge_w & ~ln_s2_r;
  assign rise_w = edge_w & ln_s2_r;
  assign half_w = per_r >> 1;
  assign qtr_w  = per_r >> 2;
  assign stby_w = ln_s2_r && !edge_w && (hi_r >= STBY_CYC - 16'h0001);
  assign is_tx_w = (slot_r == sweb_pkg::SLOT_SAK) ||
                   (slot_r < sweb_pkg::SLOT_MAK && ph_r == sweb_pkg::PH_DTX);
  assign tx_bit_w = (slot_r == sweb_pkg::SLOT_SAK) ? 1'b1 : txs_r[7];
  assign bitv_w = ln_s2_r;
  // an ack slot that ends the transfer lasts one cycle past its mid edge,
  // so the drive enable drops together with the leave of the bit state
  assign leave_w = (slot_r == sweb_pkg::SLOT_SAK) &&
                   ((go_r != sweb_pkg::ST_BITS) || (nph_r == sweb_pkg::PH_DTX && !tx_valid));
  // receive slot closes on mid edge in window, transmit slot on own mid
  assign end_w = (st_r == sweb_pkg::ST_BITS) && !stby_w &&
                 (is_tx_w ? (cnt_r >= per_r + CW'(leave_w)) : (edge_w && cnt_r >= per_r - qtr_w));
  assign full_w = (bcnt_r == 2'(sweb_pkg::BUF_DEPTH));
  // judged on the shifter, which holds the command byte at its ack
  assign cmd_ok_w = (sh_r == sweb_pkg::CMD_LATCH_SET) || (sh_r == sweb_pkg::CMD_LATCH_CLR) ||
                    (sh_r == sweb_pkg::CMD_STAT_RD) ||
                    (!write_busy && ((sh_r == sweb_pkg::CMD_RD) || (sh_r == sweb_pkg::CMD_CUR_RD) ||
                     (sh_r == sweb_pkg::CMD_WR) || (sh_r == sweb_pkg::CMD_STAT_WR) ||
                     (sh_r == sweb_pkg::CMD_FILL_ZERO) || (sh_r == sweb_pkg::CMD_FILL_ONE)));

  // protocol next state
  always_comb begin
    st_nxt = st_r;
    go_nxt = go_r;
    ph_nxt = ph_r;
    nph_nxt = nph_r;
    slot_nxt = slot_r;
    cnt_nxt = cnt_r;
    per_nxt = per_r;
    nfall_nxt = nfall_r;
    sh_nxt = sh_r;
    txs_nxt = txs_r;
    cmd_nxt = cmd_r;
    sak_nxt = sak_r;
    drv_nxt = drv_r;
    oe_nxt = oe_r;
    ws_nxt = 1'b0;
    push_w = 1'b0;
    pword_w = '{is_data: (ph_r == sweb_pkg::PH_DRX), data: sh_r};
    tx_ready = 1'b0;
    hi_nxt = (edge_w || !ln_s2_r) ? 16'h0000 : ((hi_r == 16'hffff) ? hi_r : hi_r + 16'h0001);
    if (stby_w) begin
      st_nxt = sweb_pkg::ST_STBY;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        sweb_pkg::ST_STBY: begin
          if (fall_w) begin
            st_nxt = sweb_pkg::ST_HLOW;
            cnt_nxt = '0;
          end
        end
        sweb_pkg::ST_HLOW: begin
          cnt_nxt = (cnt_r == '1) ? cnt_r : cnt_r + 1'b1;
          // header low must last its time
          if (rise_w) begin
            st_nxt = (16'(cnt_r) >= HDR_CYC - 16'h0001) ? sweb_pkg::ST_SYNC : sweb_pkg::ST_IDLE;
            nfall_nxt = 2'h0;
            cnt_nxt = '0;
          end
        end
        sweb_pkg::ST_SYNC: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == '1) begin
            st_nxt = sweb_pkg::ST_IDLE;
          end else if (fall_w) begin
            nfall_nxt = nfall_r + 2'h1;
            if (nfall_r == 2'h0) begin
              cnt_nxt = '0;
            end else if (nfall_r == 2'h2) begin
              per_nxt = (cnt_r + 1'b1) >> 2;
              st_nxt = sweb_pkg::ST_BITS;
              ph_nxt = sweb_pkg::PH_HDR;
              slot_nxt = sweb_pkg::SLOT_HDR_RESUME;
              cnt_nxt = '0;
            end
          end
        end
        sweb_pkg::ST_BITS: begin
          cnt_nxt = cnt_r + 1'b1;
          if (is_tx_w) begin
            // first half inverted, mid edge to value
            if (cnt_r == half_w) begin
              oe_nxt = (slot_r == sweb_pkg::SLOT_SAK) ? sak_r : 1'b1;
              drv_nxt = ~tx_bit_w;
            end
            if (cnt_r == per_r) begin
              drv_nxt = tx_bit_w;
            end
            // slot end restarts the bit timer
            if (end_w) begin
              cnt_nxt = '0;
            end
          end else begin
            if (cnt_r == half_w) begin
              oe_nxt = 1'b0;
            end
            if (end_w) begin
              cnt_nxt = '0;
            end else if (cnt_r > per_r + qtr_w) begin
              st_nxt = sweb_pkg::ST_IDLE;
              oe_nxt = 1'b0;
            end
          end
          if (end_w && slot_r < sweb_pkg::SLOT_MAK) begin
            sh_nxt = {sh_r[6:0], bitv_w};
            txs_nxt = {txs_r[6:0], 1'b0};
            slot_nxt = slot_r + 4'h1;
          end else if (end_w && slot_r == sweb_pkg::SLOT_MAK) begin
            // timing re-anchored on master ack edge
            slot_nxt = sweb_pkg::SLOT_SAK;
            sak_nxt = 1'b1;
            go_nxt = sweb_pkg::ST_BITS;
            // decide slave ack from master ack
            case (ph_r)
              sweb_pkg::PH_HDR: begin
                sak_nxt = 1'b0;
                go_nxt = bitv_w ? sweb_pkg::ST_BITS : sweb_pkg::ST_IDLE;
                nph_nxt = sweb_pkg::PH_ADDR;
              end
              sweb_pkg::PH_ADDR: begin
                // family and device code must match
                if (sh_r != {FAMILY, DEVCODE}) begin
                  sak_nxt = 1'b0;
                  go_nxt = sweb_pkg::ST_IDLE;
                end else if (!bitv_w) begin
                  go_nxt = sweb_pkg::ST_STBY;
                end else begin
                  nph_nxt = sweb_pkg::PH_CMD;
                end
              end
              sweb_pkg::PH_CMD: begin
                cmd_nxt = sh_r;
                if (!cmd_ok_w) begin
                  sak_nxt = 1'b0;
                  go_nxt = sweb_pkg::ST_IDLE;
                end else if (bitv_w) begin
                  if (sh_r == sweb_pkg::CMD_RD || sh_r == sweb_pkg::CMD_WR) begin
                    nph_nxt = sweb_pkg::PH_AHI;
                  end else if (sh_r == sweb_pkg::CMD_CUR_RD || sh_r == sweb_pkg::CMD_STAT_RD) begin
                    nph_nxt = sweb_pkg::PH_DTX;
                  end else if (sh_r == sweb_pkg::CMD_STAT_WR) begin
                    nph_nxt = sweb_pkg::PH_DRX;
                  end else begin
                    sak_nxt = 1'b0;
                    go_nxt = sweb_pkg::ST_IDLE;
                  end
                end else if (sh_r == sweb_pkg::CMD_FILL_ZERO || sh_r == sweb_pkg::CMD_FILL_ONE) begin
                  ws_nxt = 1'b1;
                  go_nxt = sweb_pkg::ST_STBY;
                end else if (sh_r == sweb_pkg::CMD_LATCH_SET || sh_r == sweb_pkg::CMD_LATCH_CLR) begin
                  go_nxt = sweb_pkg::ST_STBY;
                end else begin
                  sak_nxt = 1'b0;
                  go_nxt = sweb_pkg::ST_IDLE;
                end
              end
              sweb_pkg::PH_AHI, sweb_pkg::PH_ALO: begin
                if (!bitv_w || full_w) begin
                  sak_nxt = 1'b0;
                  go_nxt = sweb_pkg::ST_IDLE;
                end else begin
                  push_w = 1'b1;
                  nph_nxt = (ph_r == sweb_pkg::PH_AHI) ? sweb_pkg::PH_ALO :
                            ((cmd_r == sweb_pkg::CMD_RD) ? sweb_pkg::PH_DTX : sweb_pkg::PH_DRX);
                end
              end
              sweb_pkg::PH_DRX: begin
                if (full_w) begin
                  sak_nxt = 1'b0;
                  go_nxt = sweb_pkg::ST_IDLE;
                end else begin
                  push_w = 1'b1;
                  if (!bitv_w) begin
                    ws_nxt = 1'b1;
                    go_nxt = sweb_pkg::ST_STBY;
                  end else if (cmd_r == sweb_pkg::CMD_STAT_WR) begin
                    sak_nxt = 1'b0;
                    go_nxt = sweb_pkg::ST_IDLE;
                  end
                end
              end
              sweb_pkg::PH_DTX: begin
                go_nxt = bitv_w ? sweb_pkg::ST_BITS : sweb_pkg::ST_STBY;
              end
              default: begin
                sak_nxt = 1'b0;
                go_nxt = sweb_pkg::ST_IDLE;
              end
            endcase
          end else if (end_w) begin
            // close of slave ack slot
            slot_nxt = 4'h0;
            ph_nxt = nph_r;
            st_nxt = go_r;
            if (go_r == sweb_pkg::ST_BITS && nph_r == sweb_pkg::PH_DTX) begin
              tx_ready = tx_valid;
              txs_nxt = tx_data;
              if (!tx_valid) begin
                st_nxt = sweb_pkg::ST_IDLE;
              end
            end
            if (st_nxt != sweb_pkg::ST_BITS) begin
              oe_nxt = 1'b0;
            end
          end
        end
        default: begin
          // idle: wait for standby pulse
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // protocol registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      // start idle until a standby pulse
      st_r <= sweb_pkg::ST_IDLE;
      go_r <= sweb_pkg::ST_IDLE;
      ph_r <= sweb_pkg::PH_HDR;
      nph_r <= sweb_pkg::PH_HDR;
      slot_r <= 4'h0;
      cnt_r <= '0;
      per_r <= '0;
      nfall_r <= 2'h0;
      hi_r <= 16'h0000;
      sh_r <= 8'h00;
      txs_r <= 8'h00;
      cmd_r <= 8'h00;
      sak_r <= 1'b0;
      drv_r <= 1'b1;
      oe_r <= 1'b0;
      ws_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      go_r <= go_nxt;
      ph_r <= ph_nxt;
      nph_r <= nph_nxt;
      slot_r <= slot_nxt;
      cnt_r <= cnt_nxt;
      per_r <= per_nxt;
      nfall_r <= nfall_nxt;
      hi_r <= hi_nxt;
      sh_r <= sh_nxt;
      txs_r <= txs_nxt;
      cmd_r <= cmd_nxt;
      sak_r <= sak_nxt;
      drv_r <= drv_nxt;
      oe_r <= oe_nxt;
      ws_r <= ws_nxt;
    end
  end

  // buffer pointers; a full buffer refuses the byte with no ack
  assign pop_w = rx_valid && rx_ready;
  always_comb begin
    wp_nxt = push_w ? ~wp_r : wp_r;
    rp_nxt = pop_w ? ~rp_r : rp_r;
    bcnt_nxt = bcnt_r + {1'b0, push_w} - {1'b0, pop_w};
  end

  // buffer storage and pointers
  always_ff @(posedge mclk) begin
    if (reset) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      bcnt_r <= 2'h0;
      buf_r[0] <= '0;
      buf_r[1] <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      bcnt_r <= bcnt_nxt;
      if (push_w) begin
        buf_r[wp_r] <= pword_w;
      end
    end
  end

  assign rx_valid = (bcnt_r != 2'h0);
  assign rx_word = buf_r[rp_r];
  assign serial_line_out = drv_r;
  assign serial_line_oe = oe_r;
  assign write_start = ws_r;
  assign cmd_code = cmd_r;
  assign standby = (st_r == sweb_pkg::ST_STBY);
  assign idle = (st_r == sweb_pkg::ST_IDLE);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  release_a: assert property (serial_line_oe |-> st_r == sweb_pkg::ST_BITS)
    else $error("line driven outside a transfer");
  stby_pulse_a: assert property (stby_w |=> st_r == sweb_pkg::ST_STBY && !serial_line_oe)
    else $error("standby pulse not honoured");
  wake_a: assert property (st_r == sweb_pkg::ST_STBY && fall_w && !stby_w |=> st_r == sweb_pkg::ST_HLOW)
    else $error("falling edge did not wake slave");
  hdr_slave_ack_missing_a: assert property (ph_r == sweb_pkg::PH_HDR && slot_r == sweb_pkg::SLOT_SAK |-> !oe_nxt)
    else $error("ack driven after header");
  missed_edge_a: assert property (st_r == sweb_pkg::ST_BITS && !is_tx_w && !end_w && !stby_w &&
    cnt_r > per_r + qtr_w |=> idle)
    else $error("missed edge did not idle");
  wstart_a: assert property (write_start |-> $past(ph_r) == sweb_pkg::PH_DRX ||
    cmd_r == sweb_pkg::CMD_FILL_ZERO || cmd_r == sweb_pkg::CMD_FILL_ONE)
    else $error("write cycle without data");
  cmd_reg_a: assert property ($changed(cmd_r) |-> $past(ph_r) == sweb_pkg::PH_CMD)
    else $error("command register changed outside command byte");
  msb_out_a: assert property (st_r == sweb_pkg::ST_BITS && is_tx_w && slot_r < sweb_pkg::SLOT_MAK &&
    cnt_r == per_r && !stby_w |=> serial_line_out == $past(txs_r[7]))
    else $error("transmit bit order wrong");
  latch_mak_a: assert property (end_w && slot_r == sweb_pkg::SLOT_MAK && ph_r == sweb_pkg::PH_CMD &&
    bitv_w && sh_r == sweb_pkg::CMD_LATCH_SET |=> go_r == sweb_pkg::ST_IDLE && !sak_r)
    else $error("continue after latch command not idled");
  sak_edge_a: assert property (slot_r == sweb_pkg::SLOT_SAK && sak_r && st_r == sweb_pkg::ST_BITS &&
    cnt_r == per_r && !stby_w |=> serial_line_oe && serial_line_out)
    else $error("slave ack not high after mid edge");
  hdr_done_c: cover property (st_r == sweb_pkg::ST_BITS && ph_r == sweb_pkg::PH_ADDR);
  wstart_c: cover property (write_start);
  tx_byte_c: cover property (tx_ready);
  idle_c: cover property ($rose(idle));
endmodule
`default_nettype wire

// *** verification/sweb_master_model.sv ***
// sweb_master_model: bus master on the single-wire line
// assumes the bench pulls the line high and resolves all drivers
`timescale 1ns/1ps
`default_nettype none
module sweb_master_model #(
  parameter int T    = 100, // bit period in mclk cycles
  parameter int STBY = 400  // standby pulse, above the slave's limit
) (
  input  wire logic mclk,
  input  wire logic line,
  output logic      pull_low
);
  // line released at start
  initial pull_low = 1'b0;
  // step n edges, then move just after the edge
  task automatic wait_c(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one has a rising mid edge
  task automatic send_bit(input logic b);
    pull_low = b;
    wait_c(T/2);
    pull_low = !b;
    wait_c(T/2);
  endtask
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      send_bit(v[i]);
    end
  endtask
  // master hands over the slot
  // released slot: sample both halves, mid edge means a real bit
  task automatic get_bit(output logic b, output logic ok);
    logic h1;
    pull_low = 1'b0;
    wait_c(T/4);
    h1 = line;
    wait_c(T/2);
    b = line;
    ok = (h1 !== b);
    wait_c(T/4);
  endtask
  // called only once the slave has let go
  task automatic standby_pulse();
    pull_low = 1'b0;
    wait_c(STBY);
  endtask
  // byte, master bit, then the slave's slot
  task automatic frame(input logic [7:0] v, input logic cont, output logic ack);
    logic b;
    send_byte(v);
    send_bit(cont);
    get_bit(b, ack);
    ack = ack & b;
  endtask
  // gap, long low, sync byte, continue
  task automatic header(output logic ack);
    pull_low = 1'b0;
    wait_c(110);
    pull_low = 1'b1;
    wait_c(60);
    frame(8'h55, 1'b1, ack);
  endtask
  // slave byte, msb first; ok drops on any missing mid edge
  task automatic recv_byte(output logic [7:0] v, output logic ok);
    logic e;
    ok = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      get_bit(v[i], e);
      ok = ok & e;
    end
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// tb: self-checking bench for the single-wire bus slave
// assumes sweb_pkg and the master model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] ADDR = {sweb_pkg::FAMILY_CODE, sweb_pkg::DEVICE_CODE};
  logic                 mclk, reset, write_busy, rx_ready, tx_valid, pull_low, ok, e, b;
  logic                 serial_line_out, serial_line_oe, write_start, standby, idle, rx_valid, tx_ready;
  logic [7:0]           tx_data, cmd_code, v;
  sweb_pkg::sweb_word_t rx_word;
  wire logic            line;
  int                   num_errors, tests_run, cyc, ws_n, ws0, tr_n;
  // open line: pulled high, low if either side pulls
  assign line = !(pull_low || (serial_line_oe && !serial_line_out));
  // short standby limit keeps the run brief
  sweb_slave #(.STBY_CYC(16'd300)) sweb_slave_i (
    .mclk(mclk), .reset(reset), .serial_line_in(line), .serial_line_out(serial_line_out),
    .serial_line_oe(serial_line_oe), .write_busy(write_busy), .write_start(write_start),
    .cmd_code(cmd_code), .standby(standby), .idle(idle), .rx_word(rx_word), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  sweb_master_model mst (.mclk(mclk), .line(line), .pull_low(pull_low));
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  // count write pulses; cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (write_start === 1'b1) ws_n++;
    if (tx_ready === 1'b1) tr_n++;
    if (cyc == 90000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // optional standby pulse, header, own address, command
  task automatic start(input logic sb, input logic [7:0] cmd, input logic cont, output logic ack);
    ws0 = ws_n;
    if (sb) mst.standby_pulse();
    mst.header(e);
    check(9'(e), 9'h0);
    mst.frame(ADDR, 1'b1, e);
    check(9'(e), 9'h1);
    mst.frame(cmd, cont, ack);
  endtask
  task automatic t_latch();
    start(1'b1, sweb_pkg::CMD_LATCH_SET, 1'b0, ok);
    check(9'(ok), 9'h1);
    mst.wait_c(10);
    check(9'(cmd_code), 9'h096);
    check(9'(standby), 9'h1);
  endtask
  // no standby pulse after a clean end
  task automatic t_fill();
    logic [7:0] c [2] = '{sweb_pkg::CMD_FILL_ONE, sweb_pkg::CMD_FILL_ZERO};
    for (int i = 0; i < 2; i++) begin
      start(1'b0, c[i], 1'b0, ok);
      check(9'(ok), 9'h1);
      mst.wait_c(10);
      check(9'(ws_n - ws0), 9'h1);
      check(9'(standby), 9'h1);
    end
  endtask
  task automatic t_cont();
    logic [7:0] c [4] = '{sweb_pkg::CMD_LATCH_SET, sweb_pkg::CMD_LATCH_CLR,
                          sweb_pkg::CMD_FILL_ONE, sweb_pkg::CMD_FILL_ZERO};
    for (int i = 0; i < 4; i++) begin
      start(1'b1, c[i], 1'b1, ok);
      check(9'(ok), 9'h0);
      mst.wait_c(5);
      check(9'(idle), 9'h1);
      check(9'(ws_n - ws0), 9'h0);
    end
  endtask
  // foreign address, then a header that must be ignored
  task automatic t_bad_addr();
    mst.standby_pulse();
    mst.header(e);
    mst.frame(ADDR ^ 8'h01, 1'b1, ok);
    check(9'(ok), 9'h0);
    mst.wait_c(5);
    check(9'(idle), 9'h1);
    mst.header(e);
    mst.frame(ADDR, 1'b1, ok);
    check(9'(ok), 9'h0);
  endtask
  // write-type commands ended before any data
  task automatic t_early();
    logic [7:0] c [2] = '{sweb_pkg::CMD_WR, sweb_pkg::CMD_STAT_WR};
    for (int i = 0; i < 2; i++) begin
      start(1'b1, c[i], 1'b0, ok);
      check(9'(ok), 9'h0);
      mst.wait_c(5);
      check(9'(ws_n - ws0), 9'h0);
    end
  endtask
  task automatic t_busy();
    write_busy = 1'b1;
    start(1'b1, sweb_pkg::CMD_RD, 1'b1, ok);
    check(9'(ok), 9'h0);
    mst.wait_c(5);
    check(9'(idle), 9'h1);
    write_busy = 1'b0;
  endtask
  // status read of two bytes, the second asked for by a continue
  task automatic t_read();
    logic [7:0] d [2] = '{8'hb4, 8'h69};
    int         tr0;
    tr0 = tr_n;
    tx_data = d[0];
    tx_valid = 1'b1;
    start(1'b1, sweb_pkg::CMD_STAT_RD, 1'b1, ok);
    check(9'(ok), 9'h1);
    for (int i = 0; i < 2; i++) begin
      mst.recv_byte(v, e);
      tx_data = d[1];
      check(9'(v), 9'(d[i]));
      check(9'(e), 9'h1);
      mst.send_bit(i == 0);
      mst.get_bit(b, e);
      check(9'(b & e), 9'h1);
    end
    tx_valid = 1'b0;
    check(9'(tr_n - tr0), 9'h002);
    mst.wait_c(10);
    check(9'(standby), 9'h1);
  endtask
  // receiver stalls: two address bytes fill the buffer, data is refused
  task automatic t_buffer();
    start(1'b1, sweb_pkg::CMD_WR, 1'b1, ok);
    rx_ready = 1'b0;
    mst.frame(8'h01, 1'b1, ok);
    check(9'(ok), 9'h1);
    mst.frame(8'h23, 1'b1, ok);
    check(9'(ok), 9'h1);
    mst.frame(8'h5a, 1'b0, ok);
    check(9'(ok), 9'h0);
    check(9'(idle), 9'h1);
    check(rx_word, 9'h001);
    rx_ready = 1'b1;
    mst.wait_c(1);
    rx_ready = 1'b0;
    check(rx_word, 9'h023);
    rx_ready = 1'b1;
    mst.wait_c(1);
    check(9'(rx_valid), 9'h0);
    check(9'(ws_n - ws0), 9'h0);
  endtask
  initial begin
    reset = 1'b1;
    write_busy = 1'b0;
    rx_ready = 1'b1;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    repeat (4) @(posedge mclk);
    #1 reset = 1'b0;
    check(9'(idle), 9'h1);
    check(9'(serial_line_oe), 9'h0);
    t_latch();
    t_fill();
    t_cont();
    t_bad_addr();
    t_early();
    t_busy();
    t_read();
    t_buffer();
    wrap_up();
  end
endmodule
`default_nettype wire
